/* mms_pkg.sv */
// Package: constants and carriers for the module management status timing block.
// Function
// RULE1: After power-on or insertion, become fully functional within 2000 ms.
// RULE2: A reset pin low for over 2 us is taken as a module reset.
// RULE3: Answer the 2-wire management bus no later than 2000 ms after power-on.
// RULE4: Within 2000 ms clear monitor-not-ready status bit 0 and assert interrupt.
// RULE5: After the reset pin rises, become fully functional within 2000 ms.
// RULE6: Low-power pin high drops the module to low power within 100 us.
// RULE7: Any interrupt condition drives the interrupt output low within 200 ms.
// RULE8: After a flag is cleared by read, release interrupt within 500 us.
// RULE9: Read deadlines start at the clock fall after the read stop bit.
// RULE10: Receive loss sets its flag and asserts interrupt within 100 ms.
// RULE11: Transmit fault sets its flag and asserts interrupt within 200 ms.
// RULE12: Any other condition sets its flag and asserts interrupt within 200 ms.
// RULE13: A set mask bit inhibits its source's interrupt within 100 ms.
// RULE14: A cleared mask bit resumes its source's interrupt within 100 ms.
// RULE15: Select pin asserted starts bus responses within 100 us.
// RULE16: Select pin deasserted stops bus responses within 100 us.
// RULE17: Power-down bit written one enters low power within 100 ms.
// RULE18: Power-down bit written zero returns to full function within 300 ms.
// RULE19: Write deadlines start at the clock fall after the write stop bit.
// RULE20: After interrupt, the host reads flag bytes to find channel and type.
// RULE21: Deadlines come from internal-clock counters with configurable terminal counts.
package mms_pkg;
  localparam int CLK_HZ      = 25_000_000;
  localparam int CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int CYC_PER_MS  = CLK_HZ / 1_000;
  localparam int T_INIT_MS   = 2000;
  localparam int T_RST_MIN_US = 2;
  localparam int T_LP_US     = 100;
  localparam int INIT_CYC    = T_INIT_MS * CYC_PER_MS;
  localparam int RST_MIN_CYC = T_RST_MIN_US * CYC_PER_US;
  localparam int LP_MAX_CYC  = T_LP_US * CYC_PER_US;
  localparam int FLAG_W      = 8;
  localparam int FLAG_RX_LOS = 0;
  localparam int FLAG_TX_FLT = 1;
  // Pin synchroniser lanes.
  localparam int SY_RST = 0;
  localparam int SY_SEL = 1;
  localparam int SY_LP  = 2;
  localparam int SY_SCL = 3;
  localparam int SY_SDA = 4;
  localparam int SY_W   = 5;
  // Synchroniser reset matches the idle pin levels, so no false edge or low-power blip follows reset.
  localparam logic [SY_W-1:0]   SYNC_RST  = 5'h1B;
  localparam logic [FLAG_W-1:0] FLAG_RST  = 8'h00;
  localparam logic [FLAG_W-1:0] MASK_RST  = 8'h00;
  localparam logic              IRQ_N_RST = 1'b1;
  localparam logic              NRDY_RST  = 1'b1;

  typedef enum logic [1:0] {ST_INIT, ST_RUN, ST_HOLD} mms_state_e;

  // One management access from the serial bus engine, applied at the
  // first clock fall after the stop bit.
  typedef struct packed {
    logic [FLAG_W-1:0] rd_clr;
    logic              rd_rdy;
    logic              wr_mask;
    logic [FLAG_W-1:0] mask;
    logic              wr_pdown;
    logic              pdown;
  } mms_req_s;

  localparam mms_req_s REQ_RST = '0;
endpackage

/* mms_ctrl.sv */
// Module: status, interrupt, reset and power timing of the management side.
module mms_ctrl #(
  parameter int INIT_CYC    = mms_pkg::INIT_CYC,
  parameter int RST_MIN_CYC = mms_pkg::RST_MIN_CYC
) (
  // Clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      nrst_in,
  // Host pins
  input  wire logic                      module_rst_n_in,
  input  wire logic                      bus_select_n_in,
  input  wire logic                      low_power_pin_in,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  // Serial bus engine and condition sources
  input  wire logic                      req_valid_in,
  input  wire mms_pkg::mms_req_s         req_in,
  input  wire logic [mms_pkg::FLAG_W-1:0] cond_in,
  // Status and control
  output logic                           irq_out_n_out,
  output logic                           not_ready_out,
  output logic                           bus_respond_out,
  output logic                           low_power_out,
  output logic                           pdown_out,
  output logic [mms_pkg::FLAG_W-1:0]     flags_out,
  output logic [mms_pkg::FLAG_W-1:0]     mask_out
);
  localparam int CW = $clog2(INIT_CYC + 1);
  localparam int RW = $clog2(RST_MIN_CYC + 1);
  localparam int FW = mms_pkg::FLAG_W;

  function automatic logic mms_rise(input logic p, input logic c);
    return ~p & c;
  endfunction

  function automatic logic mms_fall(input logic p, input logic c);
    return p & ~c;
  endfunction

  // Pin synchroniser; stage one is read only by stage two.
  logic [mms_pkg::SY_W-1:0] sy1_ff, sy2_ff, sy3_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      sy1_ff <= mms_pkg::SYNC_RST;
      sy2_ff <= mms_pkg::SYNC_RST;
      sy3_ff <= mms_pkg::SYNC_RST;
    end else begin
      sy1_ff <= {sda_in, scl_in, low_power_pin_in, bus_select_n_in, module_rst_n_in};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  logic scl_fall, stop_seen, rst_rise, rst_low, sel_on, lp_pin;
  always_comb begin
    scl_fall  = mms_fall(sy3_ff[mms_pkg::SY_SCL], sy2_ff[mms_pkg::SY_SCL]);
    stop_seen = sy3_ff[mms_pkg::SY_SCL] & sy2_ff[mms_pkg::SY_SCL]
              & mms_rise(sy3_ff[mms_pkg::SY_SDA], sy2_ff[mms_pkg::SY_SDA]);
    rst_rise  = mms_rise(sy3_ff[mms_pkg::SY_RST], sy2_ff[mms_pkg::SY_RST]);
    rst_low   = ~sy2_ff[mms_pkg::SY_RST];
    sel_on    = ~sy2_ff[mms_pkg::SY_SEL];
    lp_pin    = sy2_ff[mms_pkg::SY_LP];
  end

  // Reset and initialisation sequencing.
  mms_pkg::mms_state_e state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [RW-1:0] rlow_ff, nxt_rlow;
  logic          nrdy_ff, nxt_nrdy;
  logic          rdy_ev;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_nrdy  = nrdy_ff;
    rdy_ev    = 1'b0;
    // A glitch shorter than the minimum pulse never resets the module.
    if (rst_low && rlow_ff != RW'(RST_MIN_CYC)) begin
      nxt_rlow = rlow_ff + RW'(1); // RULE21
    end else if (rst_low) begin
      nxt_rlow = rlow_ff;
    end else begin
      nxt_rlow = '0;
    end
    case (state_ff)
      mms_pkg::ST_INIT: begin
        if (cnt_ff == CW'(INIT_CYC - 1)) begin
          nxt_state = mms_pkg::ST_RUN; // RULE1
          nxt_nrdy  = 1'b0; // RULE4
          rdy_ev    = 1'b1; // RULE4
        end else begin
          nxt_cnt = cnt_ff + CW'(1); // RULE21
        end
      end
      mms_pkg::ST_HOLD: begin
        if (rst_rise) begin
          nxt_state = mms_pkg::ST_INIT; // RULE5
          nxt_cnt   = '0;
        end
      end
      default: ;
    endcase
    if (rst_low && rlow_ff == RW'(RST_MIN_CYC - 1)) begin
      nxt_state = mms_pkg::ST_HOLD; // RULE2
      nxt_nrdy  = mms_pkg::NRDY_RST;
      rdy_ev    = 1'b0;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      state_ff <= mms_pkg::ST_INIT;
      cnt_ff   <= '0;
      rlow_ff  <= '0;
      nrdy_ff  <= mms_pkg::NRDY_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rlow_ff  <= nxt_rlow;
      nrdy_ff  <= nxt_nrdy;
    end
  end

  // Accesses wait for the first clock fall after the bus stop bit.
  mms_pkg::mms_req_s pend_ff, nxt_pend;
  logic              pv_ff, nxt_pv, arm_ff, nxt_arm, commit;
  always_comb begin
    commit   = arm_ff & scl_fall; // RULE9 RULE19
    nxt_pend = pend_ff;
    nxt_pv   = pv_ff;
    nxt_arm  = arm_ff;
    if (commit) begin
      nxt_pv   = 1'b0;
      nxt_arm  = 1'b0;
      nxt_pend = mms_pkg::REQ_RST;
    end else if (stop_seen && pv_ff) begin
      nxt_arm = 1'b1;
    end
    if (req_valid_in) begin
      nxt_pv          = 1'b1;
      nxt_pend.rd_clr = nxt_pend.rd_clr | req_in.rd_clr;
      nxt_pend.rd_rdy = nxt_pend.rd_rdy | req_in.rd_rdy;
      if (req_in.wr_mask) begin
        nxt_pend.wr_mask = 1'b1;
        nxt_pend.mask    = req_in.mask;
      end
      if (req_in.wr_pdown) begin
        nxt_pend.wr_pdown = 1'b1;
        nxt_pend.pdown    = req_in.pdown;
      end
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pend_ff <= mms_pkg::REQ_RST;
      pv_ff   <= 1'b0;
      arm_ff  <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      pv_ff   <= nxt_pv;
      arm_ff  <= nxt_arm;
    end
  end

  // Flags, mask, power and interrupt output.
  logic [FW-1:0] cond_ff, flag_ff, nxt_flag, mask_ff, nxt_mask;
  logic          rdyf_ff, nxt_rdyf, pdown_ff, nxt_pdown;
  logic          irq_n_ff, nxt_irq_n, lp_ff, nxt_lp, resp_ff, nxt_resp;
  logic          run;
  logic          irq_cause;
  logic [FW-1:0] clr, set;
  always_comb begin
    run = (state_ff == mms_pkg::ST_RUN);
    clr = commit ? pend_ff.rd_clr : '0;
    set = run ? (cond_in & ~cond_ff) : '0;
    // A new event in the clearing cycle survives the clear.
    nxt_flag = (flag_ff & ~clr) | set; // RULE10 RULE11 RULE12
    nxt_rdyf = (rdyf_ff & ~(commit & pend_ff.rd_rdy)) | rdy_ev;
    nxt_mask  = (commit && pend_ff.wr_mask) ? pend_ff.mask : mask_ff; // RULE13 RULE14
    nxt_pdown = (commit && pend_ff.wr_pdown) ? pend_ff.pdown : pdown_ff;
    if (state_ff == mms_pkg::ST_HOLD) begin
      nxt_flag = mms_pkg::FLAG_RST;
      nxt_rdyf = 1'b0;
    end
    // The cause is a net of its own so that the checks can look back at it.
    irq_cause = |(flag_ff & ~mask_ff) | rdyf_ff;
    nxt_irq_n = ~irq_cause; // RULE7 RULE8
    nxt_lp    = lp_pin | pdown_ff; // RULE6 RULE17 RULE18
    nxt_resp  = run & sel_on; // RULE3 RULE15 RULE16
  end
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cond_ff  <= mms_pkg::FLAG_RST;
      flag_ff  <= mms_pkg::FLAG_RST;
      mask_ff  <= mms_pkg::MASK_RST;
      rdyf_ff  <= 1'b0;
      pdown_ff <= 1'b0;
      irq_n_ff <= mms_pkg::IRQ_N_RST;
      lp_ff    <= 1'b0;
      resp_ff  <= 1'b0;
    end else begin
      cond_ff  <= cond_in;
      flag_ff  <= nxt_flag;
      mask_ff  <= nxt_mask;
      rdyf_ff  <= nxt_rdyf;
      pdown_ff <= nxt_pdown;
      irq_n_ff <= nxt_irq_n;
      lp_ff    <= nxt_lp;
      resp_ff  <= nxt_resp;
    end
  end

  always_comb begin
    irq_out_n_out   = irq_n_ff;
    not_ready_out   = nrdy_ff;
    bus_respond_out = resp_ff;
    low_power_out   = lp_ff;
    pdown_out       = pdown_ff;
    flags_out       = flag_ff;
    mask_out        = mask_ff;
  end

  // Checks.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  init_done_a: assert property ( // RULE1
    state_ff == mms_pkg::ST_INIT && cnt_ff == CW'(INIT_CYC - 1) && !rst_low
    |=> state_ff == mms_pkg::ST_RUN ##1 !irq_out_n_out)
    else $error("init did not complete");
  ready_bit_a: assert property ( // RULE4
    $fell(not_ready_out) |-> ##1 !irq_out_n_out)
    else $error("ready without interrupt");
  rst_pulse_a: assert property ( // RULE2
    $rose(state_ff == mms_pkg::ST_HOLD) |-> $past(rlow_ff) == RW'(RST_MIN_CYC - 1))
    else $error("reset taken at wrong pulse length");
  rst_release_a: assert property ( // RULE5
    state_ff == mms_pkg::ST_HOLD && rst_rise && !rst_low
    |=> state_ff == mms_pkg::ST_INIT && cnt_ff == '0)
    else $error("init not restarted");
  bus_ready_a: assert property ( // RULE3
    bus_respond_out |-> $past(state_ff) == mms_pkg::ST_RUN)
    else $error("bus answered before ready");
  sel_on_a: assert property ( // RULE15
    run && sel_on |=> bus_respond_out)
    else $error("select not honoured");
  sel_off_a: assert property ( // RULE16
    !sel_on |=> !bus_respond_out)
    else $error("deselect not honoured");
  lp_pin_a: assert property ( // RULE6
    lp_pin |=> low_power_out)
    else $error("low power pin ignored");
  pdown_on_a: assert property ( // RULE17
    pdown_out |=> low_power_out)
    else $error("power down ignored");
  pdown_off_a: assert property ( // RULE18
    !pdown_out && !lp_pin |=> !low_power_out)
    else $error("power not restored");
  los_flag_a: assert property ( // RULE10
    run && mms_rise(cond_ff[mms_pkg::FLAG_RX_LOS], cond_in[mms_pkg::FLAG_RX_LOS])
    |=> flags_out[mms_pkg::FLAG_RX_LOS])
    else $error("loss flag not set");
  flt_flag_a: assert property ( // RULE11
    run && mms_rise(cond_ff[mms_pkg::FLAG_TX_FLT], cond_in[mms_pkg::FLAG_TX_FLT])
    |=> flags_out[mms_pkg::FLAG_TX_FLT])
    else $error("fault flag not set");
  irq_set_a: assert property ( // RULE12
    run && |(cond_in & ~cond_ff & ~mask_ff) && !commit |=> ##1 !irq_out_n_out)
    else $error("flag did not raise interrupt");
  irq_gate_a: assert property ( // RULE7
    !irq_out_n_out |-> $past(irq_cause))
    else $error("interrupt without cause");
  // A commit may unmask a standing flag, so the release looks at the mask about to apply.
  irq_release_a: assert property ( // RULE8
    commit && (flag_ff & ~nxt_mask & ~pend_ff.rd_clr) == '0 && !rdyf_ff
    && run && cond_in == cond_ff |=> ##1 irq_out_n_out)
    else $error("interrupt not released");
  mask_apply_a: assert property ( // RULE13
    commit && pend_ff.wr_mask |=> mask_out == $past(pend_ff.mask))
    else $error("mask write lost");
  mask_hold_a: assert property ( // RULE19
    $changed(mask_out) || $changed(pdown_out) |-> $past(commit))
    else $error("write applied before stop fall");
  clear_time_a: assert property ( // RULE9
    $fell(rdyf_ff) |-> $past(commit))
    else $error("clear applied before stop fall");
  hold_clear_a: assert property ( // RULE2
    state_ff == mms_pkg::ST_HOLD |=> flags_out == mms_pkg::FLAG_RST && not_ready_out)
    else $error("pin reset left state behind");
  rdy_clear_a: assert property ( // RULE8
    commit && pend_ff.rd_rdy && run |=> !rdyf_ff)
    else $error("ready flag not cleared");
  pdown_apply_a: assert property ( // RULE17
    commit && pend_ff.wr_pdown |=> pdown_out == $past(pend_ff.pdown))
    else $error("power down write lost");

  init_c: cover property ($fell(not_ready_out));
  hold_c: cover property (state_ff == mms_pkg::ST_HOLD ##[1:200] state_ff == mms_pkg::ST_INIT);
  clear_c: cover property (commit && |pend_ff.rd_clr);
  mask_c: cover property (commit && pend_ff.wr_mask);
  pdown_c: cover property (commit && pend_ff.wr_pdown);
endmodule

/* mms_host.sv */
// Host-side model: drives the reset, select and low-power pins and frames 2-wire stops.
module mms_host (
  // Clock
  input  wire logic sys_clk_in,
  // Host pins
  output logic      module_rst_n_out,
  output logic      bus_select_n_out,
  output logic      low_power_pin_out,
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both bus lines idle high on their pull-ups, so the serial clock stands still between frames.
  initial begin
    module_rst_n_out  = 1'b1;
    bus_select_n_out  = 1'b1;
    low_power_pin_out = 1'b0;
    scl_out           = 1'b1;
    sda_out           = 1'b1;
  end

  // Pin changes land on the falling edge of the system clock.
  task automatic set_pins(input logic rst_n, input logic sel_n, input logic lp);
    @(negedge sys_clk_in);
    module_rst_n_out  = rst_n;
    bus_select_n_out  = sel_n;
    low_power_pin_out = lp;
  endtask

  // Closes a transaction: stop bit, then one serial clock fall, each phase half of 320 ns.
  task automatic stop_seq();
    @(negedge sys_clk_in);
    scl_out = 1'b0;
    sda_out = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    scl_out = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    sda_out = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    scl_out = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    scl_out = 1'b1;
  endtask
endmodule

/* mms_ctrl_bench.sv */
// Testbench for the management status and timing controller.
module mms_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 100;
  localparam int RMIN = 4;
  logic                       sys_clk_in = 1'b0;
  logic                       nrst_in    = 1'b0;
  logic                       rst_n, sel_n, lp, scl, sda;
  logic                       req_valid  = 1'b0;
  mms_pkg::mms_req_s          req        = mms_pkg::REQ_RST;
  mms_pkg::mms_req_s          rq;
  logic [mms_pkg::FLAG_W-1:0] cond       = 8'h00;
  logic                       irq_n, nrdy, resp, lpo, pdn;
  logic [mms_pkg::FLAG_W-1:0] flags, mask;
  int                         failures   = 0;
  int                         cmp_count  = 0;
  int                         cycles     = 0;
  int                         bits[3]    = '{0, 1, 5};

  always #20 sys_clk_in = ~sys_clk_in;

  mms_host u_host (.sys_clk_in(sys_clk_in), .module_rst_n_out(rst_n), .bus_select_n_out(sel_n),
    .low_power_pin_out(lp), .scl_out(scl), .sda_out(sda));

  mms_ctrl #(.INIT_CYC(INIT), .RST_MIN_CYC(RMIN)) u_dut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .module_rst_n_in(rst_n),
    .bus_select_n_in(sel_n), .low_power_pin_in(lp), .scl_in(scl), .sda_in(sda),
    .req_valid_in(req_valid), .req_in(req), .cond_in(cond), .irq_out_n_out(irq_n),
    .not_ready_out(nrdy), .bus_respond_out(resp), .low_power_out(lpo), .pdown_out(pdn),
    .flags_out(flags), .mask_out(mask));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The whole run needs well under this many cycles; a hang is cut short here.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // A request is only applied once a stop and the following serial clock fall are seen.
  task automatic access(input mms_pkg::mms_req_s r);
    @(negedge sys_clk_in);
    req_valid = 1'b1;
    req       = r;
    @(negedge sys_clk_in);
    req_valid = 1'b0;
    u_host.stop_seq();
    wait_n(8);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (nrdy !== 1'b0 && n < INIT + 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk("init_late", 8'h00, 8'((n > INIT + 3) || (n < INIT - 1)));
    @(negedge sys_clk_in);
    chk("init_irq", 8'h00, irq_n);
  endtask

  initial begin
    wait_n(4);
    nrst_in = 1'b1;
    @(negedge sys_clk_in);
    chk("rst_irq", 8'(mms_pkg::IRQ_N_RST), irq_n);
    chk("rst_nrdy", 8'(mms_pkg::NRDY_RST), nrdy);
    chk("rst_flags", mms_pkg::FLAG_RST, flags);
    chk("rst_mask", mms_pkg::MASK_RST, mask);
    chk("rst_pwr", 8'h00, {resp, lpo, pdn});
    wait_ready();
    chk("resp_unsel", 8'h00, resp);
    u_host.set_pins(1'b1, 1'b0, 1'b0);
    wait_n(6);
    chk("resp_sel", 8'h01, resp);
    u_host.set_pins(1'b1, 1'b1, 1'b0);
    wait_n(6);
    chk("resp_desel", 8'h00, resp);
    u_host.set_pins(1'b1, 1'b0, 1'b0);
    rq = mms_pkg::REQ_RST;
    rq.rd_rdy = 1'b1;
    access(rq);
    chk("rdy_clear", 8'h01, irq_n);
    foreach (bits[i]) begin
      cond[bits[i]] = 1'b1;
      wait_n(3);
      chk("flag_set", 8'h01 << bits[i], flags);
      chk("flag_irq", 8'h00, irq_n);
      cond = 8'h00;
      rq = mms_pkg::REQ_RST;
      rq.rd_clr = 8'h01 << bits[i];
      access(rq);
      chk("flag_clr", 8'h00, flags);
      chk("flag_irq_off", 8'h01, irq_n);
    end
    rq = mms_pkg::REQ_RST;
    rq.wr_mask = 1'b1;
    rq.mask = 8'h04;
    access(rq);
    chk("mask_wr", 8'h04, mask);
    cond[2] = 1'b1;
    wait_n(3);
    chk("mask_flag", 8'h04, flags);
    chk("mask_irq", 8'h01, irq_n);
    rq.mask = 8'h00;
    access(rq);
    chk("unmask_irq", 8'h00, irq_n);
    cond = 8'h00;
    rq = mms_pkg::REQ_RST;
    rq.rd_clr = 8'h04;
    access(rq);
    chk("unmask_clr", 8'h01, irq_n);
    @(negedge sys_clk_in);
    req_valid = 1'b1;
    req.wr_mask = 1'b1;
    req.mask = 8'hFF;
    @(negedge sys_clk_in);
    req_valid = 1'b0;
    wait_n(12);
    chk("no_stop", 8'h00, mask);
    rq = mms_pkg::REQ_RST;
    rq.wr_mask = 1'b1;
    rq.wr_pdown = 1'b1;
    rq.pdown = 1'b1;
    access(rq);
    chk("pdown_on", 8'h03, {pdn, lpo});
    chk("pdown_mask", 8'h00, mask);
    rq.pdown = 1'b0;
    access(rq);
    chk("pdown_off", 8'h00, {pdn, lpo});
    u_host.set_pins(1'b1, 1'b0, 1'b1);
    wait_n(5);
    chk("lp_pin", 8'h01, lpo);
    u_host.set_pins(1'b1, 1'b0, 1'b0);
    wait_n(5);
    chk("lp_pin_off", 8'h00, lpo);
    u_host.set_pins(1'b0, 1'b0, 1'b0);
    u_host.set_pins(1'b1, 1'b0, 1'b0);
    wait_n(8);
    chk("short_rst", 8'h00, nrdy);
    u_host.set_pins(1'b0, 1'b0, 1'b0);
    wait_n(RMIN + 6);
    chk("pin_rst", 8'h02, {nrdy, resp});
    chk("pin_rst_irq", 8'h01, irq_n);
    u_host.set_pins(1'b1, 1'b0, 1'b0);
    wait_ready();
    conclude();
  end
endmodule
